// ### tb/capture_compare_pwm_unit_test.sv
// Self-checking bench for the capture/compare/PWM channel.
// Assumes ccpu_top, ccpu_pin_src and the bound checker.
`timescale 1ns/10ps
`include "ccpu_defs.vh"
module capture_compare_pwm_unit_test;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [7:0] ctrl = 8'h00;
    reg wr = 1'b0;
    reg [7:0] duty = 8'h00;
    reg [7:0] per = 8'h00;
    reg [15:0] tmr = 16'h0000;
    reg clr = 1'b0;
    reg dir = 1'b1;
    reg port = 1'b0;
    reg alt = 1'b0;
    reg lvl = 1'b0;
    wire pin, apin, po, poe, ao, aoe, flag;
    wire [7:0] rh, rl;
    wire [3:0] md;
    reg [31:0] seed = 32'hc625;
    reg [15:0] last, prev, d;
    integer fail_count = 0;
    integer cmp_count = 0;
    integer i, k, n, p, cnt;
    ccpu_top i_dut
    (
        .SYS_CLK_I(clk), .RESET_I(rst), .CHANNEL_CONTROL_I(ctrl), .CHANNEL_CONTROL_WR_I(wr),
        .PWM_DUTY_REGISTER_I(duty), .PWM_PERIOD_REGISTER_I(per), .PERIOD_TIMER_CONTROL_I(3'h4),
        .CAPTURE_TIMER_I(tmr), .IRQ_FLAG_CLEAR_I(clr), .PIN_DIRECTION_BIT_I(dir), .PORT_DATA_I(port),
        .ALTERNATE_PIN_SELECT_I(alt), .MODULE_PIN_I(pin), .MODULE_PIN_ALT_I(apin),
        .CAPTURE_RESULT_HIGH_O(rh), .CAPTURE_RESULT_LOW_O(rl), .CHANNEL_IRQ_FLAG_O(flag),
        .CHANNEL_MODE_FIELD_O(md), .MODULE_PIN_O(po), .MODULE_PIN_OE_O(poe), .MODULE_PIN_ALT_O(ao),
        .MODULE_PIN_ALT_OE_O(aoe)
    );
    ccpu_pin_src i_src (.clk_i(clk), .lvl_i(lvl), .alt_i(alt), .pin_o(pin), .alt_o(apin));
    // ****
    // Helpers
    // ****
    initial forever #20 clk = ~clk;
    function [31:0] xs(input [31:0] x);
        xs = x ^ (x << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task tick(input integer c);
        repeat (c) @(posedge clk);
    endtask
    task wctl(input [7:0] v);
    begin
        ctrl <= v;
        wr <= 1'b1;
        tick(1);
        wr <= 1'b0;
        tick(5);
    end
    endtask
    task clear;
    begin
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        tick(2);
    end
    endtask
    task pulse;
    begin
        seed = xs(seed);
        tmr <= seed[15:0];
        last = seed[15:0];
        lvl <= 1'b1;
        tick(8);
        lvl <= 1'b0;
        tick(8);
    end
    endtask
    task results;
    begin
        $display("compares %0d, wrong %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    initial
    begin
        tick(20000);
        fail_count = fail_count + 1;
        results;
    end
    // ****
    // Scenarios
    // ****
    initial
    begin
        tick(8);
        rst <= 1'b0;
        tick(1);
        for (i = 0; i < 4; i = i + 1)
        begin
            n = (i < 2) ? 1 : (i == 2) ? 4 : 16;
            alt <= i[1];
            wctl(8'h00);
            wctl({4'h0, `CCPU_MODE_FALL + i[3:0]});
            clear;
            chk({12'h000, md}, {12'h000, `CCPU_MODE_FALL + i[3:0]});
            for (k = 1; k < n; k = k + 1)
                pulse;
            chk(flag, 16'h0);
            pulse;
            chk({rh, rl}, last);
            chk(flag, 16'h1);
            prev = last;
            pulse;
            chk({rh, rl}, (n == 1) ? last : prev);
            clear;
            chk(flag, 16'h0);
            $display("capture mode %0d done", i);
        end
        dir <= 1'b0;
        for (i = 0; i < 4; i = i + 1)
        begin
            alt <= i[0];
            wctl(8'h00);
            seed = xs(seed);
            per <= {4'h0, seed[3:0]};
            p = (seed[3:0] + 1) * 4;
            d = (i == 0) ? 0 : (i == 1) ? seed[13:4] % p : (i == 2) ? p : 16'h3ff;
            duty <= d[9:2];
            wctl({2'b00, d[1:0], `CCPU_MODE_PWM});
            tick(3 * p + 4);
            cnt = 0;
            // Sample away from the launching edge
            for (k = 0; k < p; k = k + 1)
            begin
                @(negedge clk);
                cnt = cnt + (alt ? ao : po);
            end
            tick(1);
            chk(cnt[15:0], (d > p) ? p[15:0] : d);
            chk(alt ? aoe : poe, 16'h1);
            $display("pwm case %0d done", i);
        end
        alt <= 1'b0;
        port <= 1'b1;
        wctl(8'h00);
        chk({poe, po}, 16'h3);
        results;
    end
endmodule // capture_compare_pwm_unit_test

// ### tb/ccpu_pin_src.sv
// Signal source standing on the two module pins.
// Assumes the bench picks the level and the pin.
`timescale 1ns/10ps
module ccpu_pin_src
(
    input wire clk_i, // Clock
    input wire lvl_i, // Level
    input wire alt_i, // Use alt pin
    output reg pin_o, // Primary
    output reg alt_o // Alternative
);
    // ****
    // Unused pin wiggles so a stray capture shows
    // ****
    initial pin_o = 1'b0;
    initial alt_o = 1'b0;
    always @(posedge clk_i)
    begin
        pin_o <= alt_i ? ~pin_o : lvl_i;
        alt_o <= alt_i ? lvl_i : ~alt_o;
    end
endmodule // ccpu_pin_src

// ### tb/ccpu_properties.sv
// Port assertions for the capture/compare/PWM channel.
// Assumes the bind below onto ccpu_top.
`timescale 1ns/10ps
module ccpu_props
#(
    parameter TMR_W = 16
)
(
    input wire SYS_CLK_I, // Clock
    input wire RESET_I, // Reset
    input wire [7:0] CHANNEL_CONTROL_I, // Control
    input wire CHANNEL_CONTROL_WR_I, // Write
    input wire [TMR_W-1:0] CAPTURE_TIMER_I, // Timer
    input wire IRQ_FLAG_CLEAR_I, // Clear
    input wire PIN_DIRECTION_BIT_I, // Direction
    input wire PORT_DATA_I, // Port
    input wire ALTERNATE_PIN_SELECT_I, // Alt
    input wire [7:0] CAPTURE_RESULT_HIGH_O, // High
    input wire [7:0] CAPTURE_RESULT_LOW_O, // Low
    input wire CHANNEL_IRQ_FLAG_O, // Flag
    input wire [3:0] CHANNEL_MODE_FIELD_O, // Mode
    input wire MODULE_PIN_O, // Pin
    input wire MODULE_PIN_OE_O, // Enable
    input wire MODULE_PIN_ALT_OE_O // Alt enable
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);
    wire [15:0] res = {CAPTURE_RESULT_HIGH_O, CAPTURE_RESULT_LOW_O};
    flag_sticky_a: assert property (CHANNEL_IRQ_FLAG_O && !IRQ_FLAG_CLEAR_I |=> CHANNEL_IRQ_FLAG_O)
        else $error("flag dropped");
    flag_clear_a: assert property ($fell(CHANNEL_IRQ_FLAG_O) |-> $past(IRQ_FLAG_CLEAR_I))
        else $error("flag fell uncleared");
    result_flag_a: assert property ($changed(res) |-> CHANNEL_IRQ_FLAG_O)
        else $error("capture without flag");
    result_value_a: assert property ($changed(res) |-> res == $past(CAPTURE_TIMER_I))
        else $error("wrong timer captured");
    mode_load_a: assert property (CHANNEL_CONTROL_WR_I |-> ##2 CHANNEL_MODE_FIELD_O == $past(CHANNEL_CONTROL_I[3:0], 2))
        else $error("mode not loaded");
    input_hiz_a: assert property (PIN_DIRECTION_BIT_I [*2] |-> !MODULE_PIN_OE_O && !MODULE_PIN_ALT_OE_O)
        else $error("input pin driven");
    port_owner_a: assert property ((CHANNEL_MODE_FIELD_O == 4'h0 && !PIN_DIRECTION_BIT_I && !ALTERNATE_PIN_SELECT_I)
        [*3] |-> MODULE_PIN_OE_O && MODULE_PIN_O == $past(PORT_DATA_I)) else $error("port not driven");
    alt_route_a: assert property ((ALTERNATE_PIN_SELECT_I && !PIN_DIRECTION_BIT_I && CHANNEL_MODE_FIELD_O == 4'hc)
        [*3] |-> MODULE_PIN_ALT_OE_O && !MODULE_PIN_OE_O) else $error("alt pin unused");
endmodule // ccpu_props

bind ccpu_top ccpu_props #(.TMR_W(TMR_W)) u_chk
(
    .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .CHANNEL_CONTROL_I(CHANNEL_CONTROL_I),
    .CHANNEL_CONTROL_WR_I(CHANNEL_CONTROL_WR_I), .CAPTURE_TIMER_I(CAPTURE_TIMER_I),
    .IRQ_FLAG_CLEAR_I(IRQ_FLAG_CLEAR_I), .PIN_DIRECTION_BIT_I(PIN_DIRECTION_BIT_I), .PORT_DATA_I(PORT_DATA_I),
    .ALTERNATE_PIN_SELECT_I(ALTERNATE_PIN_SELECT_I), .CAPTURE_RESULT_HIGH_O(CAPTURE_RESULT_HIGH_O),
    .CAPTURE_RESULT_LOW_O(CAPTURE_RESULT_LOW_O), .CHANNEL_IRQ_FLAG_O(CHANNEL_IRQ_FLAG_O),
    .CHANNEL_MODE_FIELD_O(CHANNEL_MODE_FIELD_O), .MODULE_PIN_O(MODULE_PIN_O), .MODULE_PIN_OE_O(MODULE_PIN_OE_O),
    .MODULE_PIN_ALT_OE_O(MODULE_PIN_ALT_OE_O)
);

// ### verilog/ccpu_defs.vh
// Constants for the capture/compare/PWM channel.
// Assumes inclusion by bare name from each design file.
//
// Contract
// R01 - Qualified pin event copies full 16-bit capture timer into result high and low.
// R02 - Event selectable: falling, rising, every 4th rising, every 16th rising edge.
// R03 - Each capture sets the irq flag; only software clears it.
// R04 - A newer capture overwrites an unread result without any warning.
// R05 - Capture reliable only when capture timer is synchronous to system clock.
// R06 - Mode changes may raise a spurious capture flag; software clears it.
// R07 - Prescaler counter cleared when off, outside capture mode, and on reset.
// R08 - Switching prescaler ratio keeps prescaler count; may cause false capture.
// R09 - Edge detector watches pin level even while pin is driven as output.
// R10 - Second channel pin may be relocated by the alternate pin select.
// R11 - Compare needs the system clock; nothing runs while it is stopped.
// R12 - PWM mode drives a waveform of up to 10-bit duty resolution.
// R13 - Period from period register and timer control; duty from duty and control.
// R14 - PWM reaches the pin only while its direction bit selects output.
// R15 - Zero control register turns module off and returns pin to port logic.
// R16 - Output high for on part, low for off; 0% low, 100% high.
// R17 - 4-bit mode field: zero off, distinct capture, compare and PWM codes.
// R18 - Period timer match clears timer, drives high, loads next duty.
`ifndef CCPU_DEFS_VH
`define CCPU_DEFS_VH

// ****************************************
// Mode field encoding
// ****************************************
`define CCPU_MODE_OFF     4'h0
`define CCPU_MODE_CMP     4'h2
`define CCPU_MODE_FALL    4'h4
`define CCPU_MODE_RISE    4'h5
`define CCPU_MODE_RISE4   4'h6
`define CCPU_MODE_RISE16  4'h7
`define CCPU_MODE_PWM     4'hc

// ****************************************
// Widths, reset values, prescaler last counts and select codes
// ****************************************
`define CCPU_TMR_W        16
`define CCPU_PWM_W        10
`define CCPU_PSC_RESET    4'h0
`define CCPU_DIV4_LAST    4'h3
`define CCPU_DIV16_LAST   4'hf
`define CCPU_PS_1         2'h0
`define CCPU_PS_4         2'h1
`define CCPU_PS_16        2'h2

`endif

// ### verilog/ccpu_edge_presc.v
// Pin edge detector and event prescaler for capture mode.
// Assumes a pin already synchronised to the system clock.
`timescale 1ns/10ps
`include "ccpu_defs.vh"

module ccpu_edge_presc
(
    input wire clk_i,          // System clock
    input wire rst_i,          // Synchronous reset
    input wire pin_i,          // Synchronised pin level
    input wire [3:0] mode_i,   // Channel mode field
    output reg event_o         // Qualified capture event pulse
);

reg pin_last;
reg [3:0] presc;
reg capture_mode;
reg rise;
reg fall;
reg [3:0] last_count;

always @*
begin
    capture_mode = (mode_i[3:2] == 2'b01);
    rise = pin_i & ~pin_last;
    fall = ~pin_i & pin_last;
    case (mode_i)
        `CCPU_MODE_RISE4: last_count = `CCPU_DIV4_LAST;
        `CCPU_MODE_RISE16: last_count = `CCPU_DIV16_LAST;
        default: last_count = `CCPU_PSC_RESET;
    endcase
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        pin_last <= 1'b0;
        presc <= `CCPU_PSC_RESET;
        event_o <= 1'b0;
    end
    else
    begin
        pin_last <= pin_i;
        event_o <= 1'b0;
        if (!capture_mode)
        begin
            presc <= `CCPU_PSC_RESET; // R07
        end
        else if (mode_i == `CCPU_MODE_FALL)
        begin
            event_o <= fall; // R02
        end
        else if (rise)
        begin
            // Count kept across ratio changes
            if (presc >= last_count) // R08
            begin
                presc <= `CCPU_PSC_RESET;
                event_o <= 1'b1; // R02
            end
            else
            begin
                presc <= presc + 4'h1;
            end
        end
    end
end

endmodule // ccpu_edge_presc

// ### verilog/ccpu_top.v
// Capture/compare/PWM channel with 16-bit capture and 10-bit PWM.
// Assumes the capture timer value is synchronous to SYS_CLK_I.
`timescale 1ns/10ps
`include "ccpu_defs.vh"

module ccpu_top
#(
    parameter TMR_W = `CCPU_TMR_W,
    parameter PWM_W = `CCPU_PWM_W
)
(
    input wire SYS_CLK_I,                   // System clock, 25 MHz
    input wire RESET_I,                     // Synchronous reset, high
    input wire [7:0] CHANNEL_CONTROL_I,     // Control: duty LSBs [5:4], mode [3:0]
    input wire CHANNEL_CONTROL_WR_I,        // Control write strobe
    input wire [7:0] PWM_DUTY_REGISTER_I,   // Duty MSBs
    input wire [7:0] PWM_PERIOD_REGISTER_I, // Period match value
    input wire [2:0] PERIOD_TIMER_CONTROL_I,// [2] timer on, [1:0] prescale
    input wire [TMR_W-1:0] CAPTURE_TIMER_I, // Capture timer count
    input wire IRQ_FLAG_CLEAR_I,            // Clear channel irq flag
    input wire PIN_DIRECTION_BIT_I,         // 1 input, 0 output
    input wire PORT_DATA_I,                 // Port latch value
    input wire ALTERNATE_PIN_SELECT_I,      // Use alternative pin
    input wire MODULE_PIN_I,                // Primary pin level
    input wire MODULE_PIN_ALT_I,            // Alternative pin level
    output reg [7:0] CAPTURE_RESULT_HIGH_O, // Captured timer high byte
    output reg [7:0] CAPTURE_RESULT_LOW_O,  // Captured timer low byte
    output reg CHANNEL_IRQ_FLAG_O,          // Channel irq request flag
    output reg [3:0] CHANNEL_MODE_FIELD_O,  // Current mode
    output reg MODULE_PIN_O,                // Primary pin drive
    output reg MODULE_PIN_OE_O,             // Primary pin enable
    output reg MODULE_PIN_ALT_O,            // Alternative pin drive
    output reg MODULE_PIN_ALT_OE_O          // Alternative pin enable
);

// ****************************************
// Helpers
// ****************************************
function is_pwm;
    input [3:0] m;
    begin
        is_pwm = (m[3:2] == 2'b11); // R17
    end
endfunction

// ****************************************
// Control register
// ****************************************
reg [7:0] ctrl;
reg [3:0] mode;

always @(posedge SYS_CLK_I)
begin
    if (RESET_I)
        ctrl <= 8'h00;
    else if (CHANNEL_CONTROL_WR_I)
        ctrl <= CHANNEL_CONTROL_I;
end

always @*
begin
    mode = ctrl[3:0]; // R17
end

// ****************************************
// Pin select and synchroniser
// ****************************************
reg pin_meta;
reg pin_sync;
reg raw_pin;

// Pin level is read back even while driven
always @*
begin
    raw_pin = ALTERNATE_PIN_SELECT_I ? MODULE_PIN_ALT_I : MODULE_PIN_I; // R10 R09
end

always @(posedge SYS_CLK_I)
begin
    if (RESET_I)
    begin
        pin_meta <= 1'b0;
        pin_sync <= 1'b0;
    end
    else
    begin
        pin_meta <= raw_pin;
        pin_sync <= pin_meta;
    end
end

// ****************************************
// Capture
// ****************************************
wire cap_event;

ccpu_edge_presc u_edge
(
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .pin_i(pin_sync),
    .mode_i(mode),
    .event_o(cap_event)
);

always @(posedge SYS_CLK_I)
begin
    if (RESET_I)
    begin
        CAPTURE_RESULT_HIGH_O <= 8'h00;
        CAPTURE_RESULT_LOW_O <= 8'h00;
        CHANNEL_IRQ_FLAG_O <= 1'b0;
        CHANNEL_MODE_FIELD_O <= `CCPU_MODE_OFF;
    end
    else
    begin
        CHANNEL_MODE_FIELD_O <= mode;
        if (cap_event)
        begin
            // Timer sampled directly; must be synchronous
            CAPTURE_RESULT_HIGH_O <= CAPTURE_TIMER_I[TMR_W-1:TMR_W-8]; // R01 R04 R05
            CAPTURE_RESULT_LOW_O <= CAPTURE_TIMER_I[7:0]; // R01 R04
        end
        // Set wins over clear
        if (cap_event)
            CHANNEL_IRQ_FLAG_O <= 1'b1; // R03 R06
        else if (IRQ_FLAG_CLEAR_I)
            CHANNEL_IRQ_FLAG_O <= 1'b0; // R03
    end
end

// ****************************************
// Period timer and PWM
// ****************************************
reg [3:0] pre_cnt;
reg [3:0] pre_last;
reg [7:0] period_tmr;
reg [1:0] quarter;
reg [PWM_W-1:0] duty_latched;
reg pwm_level;
reg pre_tick;
reg [PWM_W-1:0] pwm_pos;
reg pwm_on;

always @*
begin
    case (PERIOD_TIMER_CONTROL_I[1:0])
        `CCPU_PS_1: pre_last = 4'h0;
        `CCPU_PS_4: pre_last = `CCPU_DIV4_LAST;
        default: pre_last = `CCPU_DIV16_LAST;
    endcase
    pre_tick = PERIOD_TIMER_CONTROL_I[2] && (pre_cnt >= pre_last);
    pwm_pos = {period_tmr, quarter};
    pwm_on = is_pwm(mode);
end

// 10-bit count = period timer bits plus two clock quarter bits
always @(posedge SYS_CLK_I)
begin
    if (RESET_I || !pwm_on)
    begin
        pre_cnt <= 4'h0;
        period_tmr <= 8'h00;
        quarter <= 2'h0;
        duty_latched <= {PWM_W{1'b0}};
        pwm_level <= 1'b0;
    end
    else
    begin
        quarter <= quarter + 2'h1;
        if (quarter == 2'h3)
        begin
            pre_cnt <= pre_tick ? 4'h0 : (PERIOD_TIMER_CONTROL_I[2] ? pre_cnt + 4'h1 : pre_cnt); // R13
            if (pre_tick)
            begin
                if (period_tmr == PWM_PERIOD_REGISTER_I) // R13 R18
                begin
                    period_tmr <= 8'h00; // R18
                    duty_latched <= {PWM_DUTY_REGISTER_I, ctrl[5:4]}; // R18 R13 R12
                end
                else
                begin
                    period_tmr <= period_tmr + 8'h01;
                end
            end
        end
        // High while position below duty; zero duty stays low
        pwm_level <= (pwm_pos < duty_latched); // R16 R18
    end
end

// ****************************************
// Pin drive
// ****************************************
reg drive_val;
reg drive_en;

always @*
begin
    if (mode == `CCPU_MODE_OFF)
    begin
        drive_val = PORT_DATA_I; // R15
        drive_en = ~PIN_DIRECTION_BIT_I; // R15
    end
    else if (pwm_on)
    begin
        drive_val = pwm_level; // R12 R16
        drive_en = ~PIN_DIRECTION_BIT_I; // R14
    end
    else
    begin
        // Capture/compare: port logic still drives if output
        drive_val = PORT_DATA_I; // R09
        drive_en = ~PIN_DIRECTION_BIT_I;
    end
end

always @(posedge SYS_CLK_I)
begin
    if (RESET_I)
    begin
        MODULE_PIN_O <= 1'b0;
        MODULE_PIN_OE_O <= 1'b0;
        MODULE_PIN_ALT_O <= 1'b0;
        MODULE_PIN_ALT_OE_O <= 1'b0;
    end
    else
    begin
        MODULE_PIN_O <= drive_val;
        MODULE_PIN_ALT_O <= drive_val;
        MODULE_PIN_OE_O <= drive_en & ~ALTERNATE_PIN_SELECT_I; // R10
        MODULE_PIN_ALT_OE_O <= drive_en & ALTERNATE_PIN_SELECT_I; // R10
    end
end

// Whole block runs on SYS_CLK_I; stopped clock halts it
// R11

endmodule // ccpu_top
